// ---- pll_tuning_pkg.sv ----
// Constants, field layout and types for the denominator and pump tuning bank
package pll_tuning_pkg;

  // Serial word shape
  localparam int WORD_W = 24;  // Bits in one loaded word
  localparam int SEL_W = 4;  // Word-select code width, low bits of the word
  localparam logic [3:0] SEL_TUNING = 4'hF;  // Code of the tuning word
  localparam logic [3:0] SEL_DENOM_HIGH = 4'hD;  // Code of the word with the upper denominator

  // Denominator geometry
  localparam int DEN_LOW_W = 12;  // Low denominator bits
  localparam int DEN_HIGH_W = 10;  // Upper denominator bits
  localparam int DEN_W = 22;  // Full extended denominator
  localparam int DEN_HIGH_LSB = 14;  // Upper bits sit at 23:14 of their word

  // Tuning word field positions
  localparam int PUMP_LSB = 5;  // Pump mode at 7:5
  localparam int BOOST_LSB = 10;  // Boost at 11:10
  localparam int DITHER_LSB = 18;  // Dither at 19:18

  // Field codes
  localparam logic [2:0] PUMP_MIN = 3'h2;
  localparam logic [2:0] PUMP_MAX = 3'h3;
  localparam logic [2:0] PUMP_NOM = 3'h7;
  localparam logic [1:0] BOOST_DOUBLE = 2'h2;
  localparam logic [1:0] BOOST_OFF = 2'h3;
  localparam logic [1:0] DITHER_ON = 2'h0;
  localparam logic [1:0] DITHER_OFF = 2'h3;

  // Values after reset: nominal pump, no boost, no dither, upper bits clear
  localparam logic [2:0] PUMP_RESET = 3'h7;
  localparam logic [1:0] BOOST_RESET = 2'h3;
  localparam logic [1:0] DITHER_RESET = 2'h3;
  localparam logic [9:0] DEN_HIGH_RESET = 10'h000;

  // Decoded pump operating mode
  typedef enum logic [1:0] {
    PUMP_MINIMUM,
    PUMP_MAXIMUM,
    PUMP_NOMINAL,
    PUMP_RESERVED
  } pump_mode_t;

endpackage : pll_tuning_pkg

// ---- serial_word_if.sv ----
// Carrier of the shifted serial word between link and system logic
`timescale 1ns/1ps
interface serial_word_if;
  logic [23:0] word;  // Last 24 bits shifted in, newest at bit 0

  // Link side owns the shift register
  modport shifter (output word);
  // System side reads it only while load enable holds it still
  modport bank (input word);
endinterface : serial_word_if

// ---- link_shift_register.sv ----
// Serial shift register on the link clock
`timescale 1ns/1ps
module link_shift_register (
  input wire logic link_clock,
  input wire logic serial_data,
  input wire logic load_enable,
  serial_word_if.shifter link
);

  logic [23:0] next_word;  // Shifted value

  // Shift msb first while load enable is low; freeze while it is high.
  // No reset here: the link clock may stand still, and the frame itself
  // fills the register before any load.
  always_comb begin
    if (load_enable) begin
      next_word = link.word;
    end else begin
      next_word = {link.word[22:0], serial_data};
    end
  end

  // Register only
  always_ff @(posedge link_clock) begin
    link.word <= next_word;
  end

endmodule : link_shift_register

// ---- pll_denominator_and_pump_tuning.sv ----
// Denominator extension and pump, boost and dither tuning bank
// Functional notes
// - Width select picks 12 or 22 bit denominator
// - Narrow mode ignores upper ten bits entirely
// - Wide mode stacks upper bits above low twelve
// - Pump codes: 2 minimum, 3 maximum, 7 nominal
// - Pump mode leaves current magnitude alone
// - Boost 2 doubles fast current, 3 none
// - Boost never touches steady pump current
// - Dither code 0 enables, code 3 disables
`timescale 1ns/1ps
module pll_denominator_and_pump_tuning #(
  parameter int CURRENT_W = 4  // Width of the pump current setting
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic link_clock,
  input wire logic serial_data,
  input wire logic load_enable,
  input wire logic denominator_width_select,
  input wire logic [11:0] denominator_low_bits,
  input wire logic [CURRENT_W-1:0] pump_current_base,
  output logic [21:0] fractional_denominator,
  output logic [2:0] pump_mode_select,
  output pll_tuning_pkg::pump_mode_t pump_mode,
  output logic [1:0] fast_acquire_boost_select,
  output logic [1:0] dither_select,
  output logic dither_enable,
  output logic [CURRENT_W-1:0] steady_pump_current,
  output logic [CURRENT_W:0] fast_acquire_current,
  output logic word_loaded
);

  // Map a pump code onto its operating mode
  function automatic pll_tuning_pkg::pump_mode_t decode_pump(input logic [2:0] code);
    unique case (code)
      pll_tuning_pkg::PUMP_MIN: decode_pump = pll_tuning_pkg::PUMP_MINIMUM;
      pll_tuning_pkg::PUMP_MAX: decode_pump = pll_tuning_pkg::PUMP_MAXIMUM;
      pll_tuning_pkg::PUMP_NOM: decode_pump = pll_tuning_pkg::PUMP_NOMINAL;
      default: decode_pump = pll_tuning_pkg::PUMP_RESERVED;  // Reserved codes
    endcase
  endfunction : decode_pump

  serial_word_if link ();  // Shifted word from the link domain

  // Link-side shifting
  link_shift_register u_shift (
    .link_clock(link_clock),
    .serial_data(serial_data),
    .load_enable(load_enable),
    .link(link.shifter)
  );

  // Load enable crossing: first stage feeds only the second
  logic le_meta;  // First synchroniser stage
  logic le_sync;  // Second synchroniser stage
  logic le_prev;  // Delayed copy for edge detection
  logic load_strobe;  // One cycle on the rise of load enable
  logic [3:0] select_code;  // Word-select code of the loaded word

  // The word is read only after load enable has been seen high twice
  // here; by then the link has stopped shifting, so the bus is still.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      le_meta <= 1'b0;
      le_prev <= 1'b0;
      le_sync <= 1'b0;
    end else begin
      le_meta <= load_enable;
      le_sync <= le_meta;
      le_prev <= le_sync;
    end
  end

  assign load_strobe = le_sync & ~le_prev;
  assign select_code = link.word[pll_tuning_pkg::SEL_W-1:0];

  // Field state
  logic [9:0] high_bits;  // Upper denominator bits
  logic [9:0] next_high_bits;
  logic [2:0] next_pump;
  logic [1:0] next_boost;
  logic [1:0] next_dither;
  logic [21:0] next_denominator;
  logic next_dither_enable;
  logic [CURRENT_W-1:0] next_steady;
  logic [CURRENT_W:0] next_fast;
  logic next_loaded;

  // Next values of every field and derived output
  always_comb begin
    next_high_bits = high_bits;
    next_pump = pump_mode_select;
    next_boost = fast_acquire_boost_select;
    next_dither = dither_select;
    next_loaded = load_strobe;
    if (load_strobe && select_code == pll_tuning_pkg::SEL_TUNING) begin
      // Unused bits of the word are simply not looked at
      next_pump = link.word[pll_tuning_pkg::PUMP_LSB +: 3];
      next_boost = link.word[pll_tuning_pkg::BOOST_LSB +: 2];
      next_dither = link.word[pll_tuning_pkg::DITHER_LSB +: 2];
    end
    if (load_strobe && select_code == pll_tuning_pkg::SEL_DENOM_HIGH) begin
      next_high_bits = link.word[pll_tuning_pkg::DEN_HIGH_LSB +: pll_tuning_pkg::DEN_HIGH_W];
    end
    // Narrow mode drops the upper bits even if the host left junk there
    if (denominator_width_select) begin
      next_denominator = {high_bits, denominator_low_bits};
    end else begin
      next_denominator = {10'h000, denominator_low_bits};
    end
    // Dither only on the enabling code; reserved codes are treated as off
    next_dither_enable = (dither_select == pll_tuning_pkg::DITHER_ON);
    // Pump mode does not enter the current path at all
    next_steady = pump_current_base;
    if (fast_acquire_boost_select == pll_tuning_pkg::BOOST_DOUBLE) begin
      next_fast = {pump_current_base, 1'b0};
    end else begin
      next_fast = {1'b0, pump_current_base};
    end
  end

  // Register the fields; reset picks nominal, unboosted, undithered
  always_ff @(posedge clock) begin
    if (!resetn) begin
      high_bits <= pll_tuning_pkg::DEN_HIGH_RESET;
      pump_mode_select <= pll_tuning_pkg::PUMP_RESET;
      fast_acquire_boost_select <= pll_tuning_pkg::BOOST_RESET;
      dither_select <= pll_tuning_pkg::DITHER_RESET;
      fractional_denominator <= 22'h000000;
      dither_enable <= 1'b0;
      steady_pump_current <= '0;
      fast_acquire_current <= '0;
      word_loaded <= 1'b0;
    end else begin
      high_bits <= next_high_bits;
      pump_mode_select <= next_pump;
      fast_acquire_boost_select <= next_boost;
      dither_select <= next_dither;
      fractional_denominator <= next_denominator;
      dither_enable <= next_dither_enable;
      steady_pump_current <= next_steady;
      fast_acquire_current <= next_fast;
      word_loaded <= next_loaded;
    end
  end

  // Mode decode straight from the held code
  assign pump_mode = decode_pump(pump_mode_select);

  // Checks on the system clock
  property p_den_narrow;
    @(posedge clock) disable iff (!resetn)
    !denominator_width_select |=>
      fractional_denominator == {10'h000, $past(denominator_low_bits)};
  endproperty
  a_den_narrow: assert property (p_den_narrow)
    else $error("narrow denominator wrong");

  property p_den_wide;
    @(posedge clock) disable iff (!resetn)
    denominator_width_select |=>
      fractional_denominator == {$past(high_bits), $past(denominator_low_bits)};
  endproperty
  a_den_wide: assert property (p_den_wide) else $error("wide denominator wrong");

  property p_width_top;
    @(posedge clock) disable iff (!resetn)
    (!denominator_width_select)[*2] |-> fractional_denominator[21:12] == 10'h000;
  endproperty
  a_width_top: assert property (p_width_top)
    else $error("upper bits leak in 12-bit mode");

  property p_tuning_update;
    @(posedge clock) disable iff (!resetn)
    load_strobe && select_code == pll_tuning_pkg::SEL_TUNING |=>
      pump_mode_select == $past(link.word[7:5]) && dither_select == $past(link.word[19:18])
      && fast_acquire_boost_select == $past(link.word[11:10]);
  endproperty
  a_tuning_update: assert property (p_tuning_update)
    else $error("tuning word not taken");

  property p_tuning_hold;
    @(posedge clock) disable iff (!resetn)
    !(load_strobe && select_code == pll_tuning_pkg::SEL_TUNING) |=>
      $stable(pump_mode_select) && $stable(fast_acquire_boost_select) && $stable(dither_select);
  endproperty
  a_tuning_hold: assert property (p_tuning_hold) else $error("tuning field changed");

  property p_pump_decode;
    @(posedge clock) disable iff (!resetn)
    pump_mode_select == 3'h7 |-> pump_mode == pll_tuning_pkg::PUMP_NOMINAL;
  endproperty
  a_pump_decode: assert property (p_pump_decode) else $error("pump nominal decode");

  property p_steady;
    @(posedge clock) disable iff (!resetn)
    $changed(pump_mode_select) |-> ##1 steady_pump_current == $past(pump_current_base);
  endproperty
  a_steady: assert property (p_steady) else $error("steady current moved");

  property p_boost_double;
    @(posedge clock) disable iff (!resetn)
    fast_acquire_boost_select == 2'h2 |=> fast_acquire_current == {$past(pump_current_base), 1'b0};
  endproperty
  a_boost_double: assert property (p_boost_double) else $error("boost not doubled");

  property p_boost_off;
    @(posedge clock) disable iff (!resetn)
    fast_acquire_boost_select == 2'h3 |=>
      fast_acquire_current == {1'b0, $past(pump_current_base)}
      && steady_pump_current == $past(pump_current_base);
  endproperty
  a_boost_off: assert property (p_boost_off) else $error("boost off wrong");

  property p_dither;
    @(posedge clock) disable iff (!resetn)
    load_strobe && select_code == 4'hF && link.word[19:18] == 2'h0 |=> ##1 dither_enable;
  endproperty
  a_dither: assert property (p_dither) else $error("dither not enabled");

  // Main scenarios
  c_tuning_load: cover property (@(posedge clock) disable iff (!resetn)
    load_strobe && select_code == pll_tuning_pkg::SEL_TUNING);
  c_wide_4096: cover property (@(posedge clock) disable iff (!resetn)
    fractional_denominator == 22'h001000);
  c_boost_double: cover property (@(posedge clock) disable iff (!resetn)
    fast_acquire_boost_select == pll_tuning_pkg::BOOST_DOUBLE);

endmodule : pll_denominator_and_pump_tuning

// ---- serial_host.sv ----
// Host model driving the three-wire serial programming link
`timescale 1ns/1ps
module serial_host (
  output logic link_clock,
  output logic serial_data,
  output logic load_enable
);
  // Idle link: clock still, load low so no stray load at reset release
  initial begin
    link_clock = 1'b0;
    serial_data = 1'b0;
    load_enable = 1'b0;
  end

  // Whole 24-bit word, first bit shifted is bit 23
  task automatic send_word(input logic [23:0] w);
    // Small offset keeps link edges away from the system clock edges
    #3;
    for (int i = 23; i >= 0; i--) begin
      serial_data = w[i];
      #16 link_clock = 1'b1;
      #16 link_clock = 1'b0;
    end
    // Load held past four system clocks, link clock stands still meanwhile
    #2 load_enable = 1'b1;
    #48 load_enable = 1'b0;
    // Released data line must not keep showing the last bit
    serial_data = ~w[0];
    #40;
  endtask : send_word
endmodule : serial_host

// ---- testbench.sv ----
// Self-checking bench for the denominator and pump tuning bank
`timescale 1ns/1ps
module testbench;
  logic clock, resetn, link_clock, serial_data, load_enable;
  logic denominator_width_select;
  logic [11:0] denominator_low_bits;
  logic [3:0] pump_current_base;
  logic [21:0] den;
  logic [2:0] pump;
  pll_tuning_pkg::pump_mode_t mode;
  logic [1:0] boost, dith;
  logic dith_en, loaded;
  logic [3:0] steady;
  logic [4:0] fast;
  int n_mismatch = 0;
  int total_checks = 0;

  pll_denominator_and_pump_tuning u_pll_denominator_and_pump_tuning (
    .clock(clock), .resetn(resetn), .link_clock(link_clock),
    .serial_data(serial_data), .load_enable(load_enable),
    .denominator_width_select(denominator_width_select),
    .denominator_low_bits(denominator_low_bits), .pump_current_base(pump_current_base),
    .fractional_denominator(den), .pump_mode_select(pump), .pump_mode(mode),
    .fast_acquire_boost_select(boost), .dither_select(dith), .dither_enable(dith_en),
    .steady_pump_current(steady), .fast_acquire_current(fast), .word_loaded(loaded)
  );
  serial_host u_serial_host (
    .link_clock(link_clock), .serial_data(serial_data), .load_enable(load_enable)
  );

  // System clock, 8 ns
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // One comparison, four-state exact
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // Expected values worked out from field meanings
  function automatic logic [21:0] exp_den(input logic ws, input logic [9:0] h,
                                          input logic [11:0] l);
    return ws ? {h, l} : {10'h000, l};
  endfunction : exp_den
  function automatic pll_tuning_pkg::pump_mode_t exp_mode(input logic [2:0] p);
    case (p)
      3'h2: return pll_tuning_pkg::PUMP_MINIMUM;
      3'h3: return pll_tuning_pkg::PUMP_MAXIMUM;
      3'h7: return pll_tuning_pkg::PUMP_NOMINAL;
      default: return pll_tuning_pkg::PUMP_RESERVED;
    endcase
  endfunction : exp_mode
  function automatic logic [23:0] tune_word(input logic [2:0] p, input logic [1:0] b,
                                            input logic [1:0] d);
    return {4'h0, d, 6'h00, b, 2'h0, p, 1'b0, pll_tuning_pkg::SEL_TUNING};
  endfunction : tune_word

  // Send a word and wait, bounded, for the load pulse
  task automatic load(input logic [23:0] w);
    int k;
    k = 0;
    fork
      u_serial_host.send_word(w);
      while (loaded !== 1'b1 && k < 150) begin
        @(posedge clock);
        #1 k++;
      end
    join
    chk("word_loaded", 24'h1, {23'h0, k < 150});
  endtask : load

  initial begin
    logic [9:0] hi_tab [4];
    logic [2:0] pt [3];
    logic [2:0] p;
    logic [1:0] b, d;
    logic [21:0] den_was;
    logic [21:0] den_exp;
    logic [4:0] fast_exp;
    hi_tab = '{10'h001, 10'h3FF, 10'h000, 10'h2A5};
    pt = '{3'h2, 3'h3, 3'h7};
    resetn = 1'b0;
    denominator_width_select = 1'b0;
    denominator_low_bits = 12'h000;
    pump_current_base = 4'h0;
    void'($urandom(32'h8c0be1ce));
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1 chk("pump reset", pll_tuning_pkg::PUMP_RESET, pump);
    chk("boost reset", pll_tuning_pkg::BOOST_RESET, boost);
    chk("dither reset", pll_tuning_pkg::DITHER_RESET, dith);
    // Both widths for each upper value; 4096 and 4194303 among them
    foreach (hi_tab[i]) begin
      load({hi_tab[i], 10'h000, pll_tuning_pkg::SEL_DENOM_HIGH});
      for (int m = 0; m < 2; m++) begin
        @(posedge clock);
        denominator_width_select <= m[0];
        denominator_low_bits <= (i < 2) ? {12{i[0]}} : 12'($urandom);
        repeat (2) @(posedge clock);
        #1 den_exp = exp_den(m[0], hi_tab[i], denominator_low_bits);
        chk("denominator", den_exp, den);
      end
    end
    // Each pump code with both boost and both dither codes
    for (int c = 0; c < 12; c++) begin
      p = pt[c % 3];
      b = ((c / 3) % 2) ? 2'h3 : 2'h2;
      d = (c / 6) ? 2'h3 : 2'h0;
      @(posedge clock);
      pump_current_base <= 4'($urandom);
      load(tune_word(p, b, d));
      chk("pump code", p, pump);
      chk("pump mode", exp_mode(p), mode);
      chk("boost", b, boost);
      chk("dither", d, dith);
      chk("dither on", d == 2'h0, dith_en);
      chk("steady", pump_current_base, steady);
      fast_exp = (b == 2'h2) ? {pump_current_base, 1'b0} : {1'b0, pump_current_base};
      chk("fast", fast_exp, fast);
    end
    // Foreign select code must leave every field alone
    den_was = den;
    load(24'hAAAAA7);
    repeat (2) @(posedge clock);
    #1 chk("pump kept", p, pump);
    chk("denominator kept", den_was, den);
    chk("boost kept", b, boost);
    chk("dither kept", d, dith);
    summarize();
  end

  // Watchdog: about 17 words of ~110 clocks each, wide margin
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
endmodule : testbench
